// [npk_regs.svh]
// Register offsets, field positions, reset values and codes of the protection block
`ifndef NPK_REGS_SVH
`define NPK_REGS_SVH

`define NPK_OFS_CONFIG 8'h00
`define NPK_OFS_PROT 8'h04
`define NPK_OFS_STATUS 8'h08
`define NPK_OFS_MASK 8'h0c

`define NPK_CFG_PAGE_BIT 6
`define NPK_CFG_KEY_BIT 5
`define NPK_CFG_RESET 8'h00
`define NPK_CFG_WMASK 8'h60

`define NPK_PROT_EEP_HI 7
`define NPK_PROT_EEP_LO 6
`define NPK_PROT_FLP_HI 5
`define NPK_PROT_FLP_LO 0
`define NPK_PROT_RESET 8'hff

`define NPK_ST_VIOL_BIT 5
`define NPK_ST_MASS_BIT 4
`define NPK_ST_KEY_BIT 1
`define NPK_ST_PREF_BIT 0
`define NPK_ST_WMASK 8'h33
`define NPK_ST_RESET 8'h00

`define NPK_KEY_BASE 16'hffb0
`define NPK_KEY_TOP 16'hffb7

`define NPK_CMD_BYTE_PROG 8'h20
`define NPK_CMD_BURST_PROG 8'h25
`define NPK_CMD_SECT_ERASE 8'h40
`define NPK_CMD_MASS_ERASE 8'h41

`define NPK_EEP_NONE 2'h3
`define NPK_EEP_BASE_2 16'h17f0
`define NPK_EEP_BASE_1 16'h17e0
`define NPK_EEP_BASE_0 16'h17c0
`define NPK_FLP_NONE 6'h3f
`define NPK_FLP_ALL_TOP 6'h18
`define NPK_FLP_STEP 17'h00600
`define NPK_FLASH_END 17'h10000

`endif

// [npk_pkg.sv]
// Types shared by the protection control block
`default_nettype none
package npk_pkg;
   typedef logic [7:0] npk_byte_t;
   typedef logic [15:0] npk_addr_t;
   typedef enum logic [1:0]
   {
      NPK_LOAD = 2'b01,
      NPK_RUN = 2'b10
   } npk_state_e;
endpackage
`default_nettype wire

// [npk_sticky.sv]
// Sticky event bits with write-one-to-clear; a set beats a clear
`default_nettype none
module npk_sticky #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flags
);
   if (W < 1)
   begin : g_bad_w
      $error("npk_sticky: W must be at least 1");
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags <= '0;
      else
         flags <= (flags & ~clr) | set;
   end
endmodule // npk_sticky
`default_nettype wire

// [npk_prot_decode.sv]
// Decodes the protection codes into a hit test for one address
`default_nettype none
`include "npk_regs.svh"
module npk_prot_decode (
   input wire logic [1:0] eeprom_protect_code,
   input wire logic [5:0] flash_protect_code,
   input wire npk_pkg::npk_addr_t addr,
   input wire logic is_eeprom,
   output logic hit,
   output logic any_protected
);
   import npk_pkg::*;
   logic [16:0] flash_low;
   logic eeprom_hit;
   logic flash_hit;

   always_comb
   begin
      flash_low = `NPK_FLASH_END
         - 17'(({11'h000, `NPK_FLP_NONE - flash_protect_code}) * `NPK_FLP_STEP);
      if (flash_protect_code == `NPK_FLP_NONE)
         flash_hit = 1'b0;
      else if (flash_protect_code <= `NPK_FLP_ALL_TOP)
         flash_hit = 1'b1;
      else
         flash_hit = {1'b0, addr} >= flash_low;
   end

   always_comb
   begin
      unique case (eeprom_protect_code)
         2'h2: eeprom_hit = addr >= `NPK_EEP_BASE_2 && addr <= 16'h17ff;
         2'h1: eeprom_hit = addr >= `NPK_EEP_BASE_1 && addr <= 16'h17ff;
         2'h0: eeprom_hit = addr >= `NPK_EEP_BASE_0 && addr <= 16'h17ff;
         2'h3: eeprom_hit = 1'b0;
      endcase
   end

   assign hit = is_eeprom ? eeprom_hit : flash_hit;
   assign any_protected = (eeprom_protect_code != `NPK_EEP_NONE)
      || (flash_protect_code != `NPK_FLP_NONE);
endmodule // npk_prot_decode
`default_nettype wire

// [npk_ctrl.sv]
// Configuration, protection and key routing for the nonvolatile memory controller
//
// Implementation choices: register access over APB and the placing of the registers.
`default_nettype none
`include "npk_regs.svh"
module npk_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire npk_pkg::npk_byte_t protection_nv_image,
   input wire logic dbg_prot_wr,
   input wire npk_pkg::npk_byte_t dbg_prot_data,
   input wire logic mem_wr_valid,
   input wire npk_pkg::npk_addr_t mem_wr_addr,
   input wire npk_pkg::npk_byte_t mem_wr_data,
   output logic key_wr,
   output logic [2:0] key_index,
   output npk_pkg::npk_byte_t key_data,
   output logic cmd_seq_start,
   input wire logic cmd_valid,
   input wire npk_pkg::npk_byte_t cmd_code,
   input wire npk_pkg::npk_addr_t cmd_addr,
   input wire logic cmd_is_eeprom,
   output logic cmd_launch,
   output logic cmd_blocked,
   output logic eeprom_page_select,
   output logic key_write_enable,
   output logic [1:0] eeprom_protect_code,
   output logic [5:0] flash_protect_code,
   output logic mass_erase_allowed,
   output logic irq
);
   import npk_pkg::*;

   // Refuse address widths the offset decode cannot serve
   if (ADDR_W < 5 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("npk_ctrl: ADDR_W must lie in 5..32");
   end

   npk_state_e state_reg;
   npk_byte_t cfg_reg;
   npk_byte_t nvm_protection_reg;
   npk_byte_t mask_reg;
   npk_byte_t status_flags;
   npk_byte_t status_set;
   npk_byte_t status_clr;
   logic ready_reg;
   logic err_reg;
   logic [7:0] off;
   logic mapped;
   logic apb_wr;
   logic key_hit;
   logic prot_hit;
   logic any_prot;
   logic is_pe_cmd;
   logic apb_prot_wr;
   logic apb_prot_ok;
   logic dbg_prot_ok;
   logic run;

   assign run = state_reg == NPK_RUN;
   assign off = 8'(paddr);
   assign mapped = off == `NPK_OFS_CONFIG || off == `NPK_OFS_PROT
      || off == `NPK_OFS_STATUS || off == `NPK_OFS_MASK;
   assign apb_wr = psel && penable && pready && pwrite && !pslverr && pstrb[0];
   assign apb_prot_wr = apb_wr && off == `NPK_OFS_PROT;

   // Reset load sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= NPK_LOAD;
      else
      begin
         unique case (state_reg)
            NPK_LOAD: state_reg <= NPK_RUN;
            NPK_RUN: state_reg <= NPK_RUN;
            default: state_reg <= NPK_LOAD;
         endcase
      end
   end

   // APB answer: one wait state, held off during the load
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         ready_reg <= psel && penable && !ready_reg && run;
         err_reg <= psel && penable && !ready_reg && run && !mapped;
         if (psel && penable && !ready_reg && run && !pwrite)
         begin
            unique case (off)
               `NPK_OFS_CONFIG: prdata <= {24'h000000, cfg_reg};
               `NPK_OFS_PROT: prdata <= {24'h000000, nvm_protection_reg};
               `NPK_OFS_STATUS: prdata <= {24'h000000, status_flags};
               `NPK_OFS_MASK: prdata <= {24'h000000, mask_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign pready = ready_reg;
   assign pslverr = err_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_reg <= `NPK_CFG_RESET;
      else if (apb_wr && off == `NPK_OFS_CONFIG)
         cfg_reg <= pwdata[7:0] & `NPK_CFG_WMASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_reg <= 8'h00;
      else if (apb_wr && off == `NPK_OFS_MASK)
         mask_reg <= pwdata[7:0] & `NPK_ST_WMASK;
   end

   assign eeprom_page_select = cfg_reg[`NPK_CFG_PAGE_BIT];
   assign key_write_enable = cfg_reg[`NPK_CFG_KEY_BIT];

   assign apb_prot_ok =
      pwdata[`NPK_PROT_EEP_HI:`NPK_PROT_EEP_LO] <= eeprom_protect_code
      && pwdata[`NPK_PROT_FLP_HI:`NPK_PROT_FLP_LO] <= flash_protect_code;
   assign dbg_prot_ok =
      dbg_prot_data[`NPK_PROT_EEP_HI:`NPK_PROT_EEP_LO] <= eeprom_protect_code
      && dbg_prot_data[`NPK_PROT_FLP_HI:`NPK_PROT_FLP_LO] <= flash_protect_code;

   // image load, widening writes; debug wins a tie
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         nvm_protection_reg <= `NPK_PROT_RESET;
      else if (state_reg == NPK_LOAD)
         nvm_protection_reg <= protection_nv_image;
      else if (dbg_prot_wr && dbg_prot_ok)
         nvm_protection_reg <= dbg_prot_data;
      else if (apb_prot_wr && apb_prot_ok)
         nvm_protection_reg <= pwdata[7:0];
   end
   assign eeprom_protect_code = nvm_protection_reg[`NPK_PROT_EEP_HI:`NPK_PROT_EEP_LO];
   assign flash_protect_code = nvm_protection_reg[`NPK_PROT_FLP_HI:`NPK_PROT_FLP_LO];

   assign key_hit = mem_wr_addr >= `NPK_KEY_BASE && mem_wr_addr <= `NPK_KEY_TOP;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_wr <= 1'b0;
         key_index <= 3'h0;
         key_data <= 8'h00;
         cmd_seq_start <= 1'b0;
      end
      else
      begin
         key_wr <= mem_wr_valid && run && key_hit && key_write_enable;
         cmd_seq_start <= mem_wr_valid && run && !(key_hit && key_write_enable);
         if (mem_wr_valid && key_hit && key_write_enable)
         begin
            key_index <= mem_wr_addr[2:0];
            key_data <= mem_wr_data;
         end
      end
   end

   npk_prot_decode u_decode (
      .eeprom_protect_code(eeprom_protect_code),
      .flash_protect_code(flash_protect_code),
      .addr(cmd_addr),
      .is_eeprom(cmd_is_eeprom),
      .hit(prot_hit),
      .any_protected(any_prot)
   );
   assign mass_erase_allowed = !any_prot;

   assign is_pe_cmd = cmd_code == `NPK_CMD_BYTE_PROG || cmd_code == `NPK_CMD_BURST_PROG
      || cmd_code == `NPK_CMD_SECT_ERASE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_launch <= 1'b0;
         cmd_blocked <= 1'b0;
      end
      else
      begin
         cmd_blocked <= cmd_valid && run && ((is_pe_cmd && prot_hit)
            || (cmd_code == `NPK_CMD_MASS_ERASE && any_prot));
         cmd_launch <= cmd_valid && run && !((is_pe_cmd && prot_hit)
            || (cmd_code == `NPK_CMD_MASS_ERASE && any_prot));
      end
   end

   // Event sources for the status register
   always_comb
   begin
      status_set = 8'h00;
      status_set[`NPK_ST_VIOL_BIT] = cmd_valid && run && ((is_pe_cmd && prot_hit)
         || (cmd_code == `NPK_CMD_MASS_ERASE && any_prot));
      status_set[`NPK_ST_MASS_BIT] = cmd_valid && run
         && cmd_code == `NPK_CMD_MASS_ERASE && any_prot;
      status_set[`NPK_ST_KEY_BIT] = mem_wr_valid && run && key_hit && key_write_enable;
      status_set[`NPK_ST_PREF_BIT] = (apb_prot_wr && !apb_prot_ok)
         || (run && dbg_prot_wr && !dbg_prot_ok);
   end
   assign status_clr = (apb_wr && off == `NPK_OFS_STATUS) ?
      (pwdata[7:0] & `NPK_ST_WMASK) : 8'h00;

   npk_sticky #(.W(8)) u_status (
      .pclk(pclk),
      .presetn(presetn),
      .set(status_set),
      .clr(status_clr),
      .flags(status_flags)
   );

   assign irq = |(status_flags & mask_reg);

   // Checks
   localparam npk_addr_t KEY_ADDR = `NPK_KEY_BASE;

   property p_page_follows_write;
      @(posedge pclk) disable iff (!presetn)
      apb_wr && off == `NPK_OFS_CONFIG |=> eeprom_page_select == $past(pwdata[6]);
   endproperty
   a_page_follows_write: assert property (p_page_follows_write)
      else $error("page select does not follow the config write");

   property p_key_as_cmd;
      @(posedge pclk) disable iff (!presetn)
      mem_wr_valid && run && key_hit && !key_write_enable |=> cmd_seq_start && !key_wr;
   endproperty
   a_key_as_cmd: assert property (p_key_as_cmd)
      else $error("key address write did not start a command");

   property p_key_as_key;
      @(posedge pclk) disable iff (!presetn)
      mem_wr_valid && run && key_hit && key_write_enable
      |=> key_wr && !cmd_seq_start && key_index == $past(mem_wr_addr[2:0]);
   endproperty
   a_key_as_key: assert property (p_key_as_key)
      else $error("key write was not routed as a key value");

   property p_image_load;
      @(posedge pclk) disable iff (!presetn)
      state_reg == NPK_LOAD |=> nvm_protection_reg == $past(protection_nv_image) && run;
   endproperty
   a_image_load: assert property (p_image_load)
      else $error("protection not loaded from the image");

   property p_no_shrink;
      @(posedge pclk) disable iff (!presetn)
      run && !dbg_prot_wr && apb_prot_wr && !apb_prot_ok |=> $stable(nvm_protection_reg);
   endproperty
   a_no_shrink: assert property (p_no_shrink)
      else $error("a shrinking protection write was taken");

   property p_grow_taken;
      @(posedge pclk) disable iff (!presetn)
      run && !dbg_prot_wr && apb_prot_wr && apb_prot_ok
      |=> nvm_protection_reg == $past(pwdata[7:0]);
   endproperty
   a_grow_taken: assert property (p_grow_taken)
      else $error("a widening protection write was lost");

   property p_dbg_write;
      @(posedge pclk) disable iff (!presetn)
      run && dbg_prot_wr && dbg_prot_ok |=> nvm_protection_reg == $past(dbg_prot_data);
   endproperty
   a_dbg_write: assert property (p_dbg_write)
      else $error("debug protection write was lost");

   property p_viol_flag;
      @(posedge pclk) disable iff (!presetn)
      cmd_valid && run && is_pe_cmd && prot_hit
      |=> cmd_blocked && !cmd_launch && status_flags[`NPK_ST_VIOL_BIT];
   endproperty
   a_viol_flag: assert property (p_viol_flag)
      else $error("protected command not blocked or flagged");

   property p_mass_refused;
      @(posedge pclk) disable iff (!presetn)
      cmd_valid && run && cmd_code == `NPK_CMD_MASS_ERASE && any_prot
      |=> cmd_blocked && !cmd_launch;
   endproperty
   a_mass_refused: assert property (p_mass_refused)
      else $error("mass erase launched under protection");

   property p_mass_code;
      @(posedge pclk) disable iff (!presetn)
      cmd_valid && run && cmd_code == 8'h41 && !any_prot |=> cmd_launch;
   endproperty
   a_mass_code: assert property (p_mass_code)
      else $error("unprotected mass erase not launched");

   property p_viol_sticky;
      @(posedge pclk) disable iff (!presetn)
      status_flags[`NPK_ST_VIOL_BIT] && !(apb_wr && off == `NPK_OFS_STATUS)
      |=> status_flags[`NPK_ST_VIOL_BIT];
   endproperty
   a_viol_sticky: assert property (p_viol_sticky)
      else $error("violation flag dropped without a clear");

   property p_eeprom_top;
      @(posedge pclk) disable iff (!presetn)
      cmd_valid && run && is_pe_cmd && cmd_is_eeprom && cmd_addr == 16'h17f0
      && eeprom_protect_code != `NPK_EEP_NONE |=> cmd_blocked;
   endproperty
   a_eeprom_top: assert property (p_eeprom_top)
      else $error("protected eeprom address not blocked");

   property p_flash_all;
      @(posedge pclk) disable iff (!presetn)
      cmd_valid && run && is_pe_cmd && !cmd_is_eeprom && flash_protect_code <= 6'h18
      |=> cmd_blocked;
   endproperty
   a_flash_all: assert property (p_flash_all)
      else $error("fully protected flash not blocked");

   c_key_write: cover property (@(posedge pclk) disable iff (!presetn)
      mem_wr_valid && mem_wr_addr == KEY_ADDR && key_write_enable);
   c_mass_block: cover property (@(posedge pclk) disable iff (!presetn)
      cmd_blocked && status_flags[`NPK_ST_MASS_BIT]);
   c_prot_grow: cover property (@(posedge pclk) disable iff (!presetn)
      apb_prot_wr && apb_prot_ok);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule // npk_ctrl
`default_nettype wire

// [npk_host_model.sv]
// Model of the processor core and debug port that drive the memory side
`default_nettype none
module npk_host_model
(
   input wire logic pclk,
   output logic mem_wr_valid,
   output npk_pkg::npk_addr_t mem_wr_addr,
   output npk_pkg::npk_byte_t mem_wr_data,
   output logic cmd_valid,
   output npk_pkg::npk_byte_t cmd_code,
   output npk_pkg::npk_addr_t cmd_addr,
   output logic cmd_is_eeprom,
   output logic dbg_prot_wr,
   output npk_pkg::npk_byte_t dbg_prot_data
);
   timeunit 1ns;
   timeprecision 100ps;
   import npk_pkg::*;

   initial
   begin
      mem_wr_valid = 1'b0;
      mem_wr_addr = 16'h0000;
      mem_wr_data = 8'h00;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_addr = 16'h0000;
      cmd_is_eeprom = 1'b0;
      dbg_prot_wr = 1'b0;
      dbg_prot_data = 8'h00;
   end

   // Released lines show the inverse so stale values never look valid
   task automatic mem_write(input npk_addr_t a, input npk_byte_t d);
      @(posedge pclk);
      mem_wr_valid <= 1'b1;
      mem_wr_addr <= a;
      mem_wr_data <= d;
      @(posedge pclk);
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= ~a;
      mem_wr_data <= ~d;
      #1;
   endtask

   task automatic command(input npk_byte_t c, input npk_addr_t a, input logic ee);
      @(posedge pclk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_is_eeprom <= ee;
      @(posedge pclk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_addr <= ~a;
      cmd_is_eeprom <= ~ee;
      #1;
   endtask

   task automatic dbg_write(input npk_byte_t d);
      @(posedge pclk);
      dbg_prot_wr <= 1'b1;
      dbg_prot_data <= d;
      @(posedge pclk);
      dbg_prot_wr <= 1'b0;
      dbg_prot_data <= ~d;
      #1;
   endtask
endmodule // npk_host_model
`default_nettype wire

// [tb_nvm_page_key_protect_ctrl.sv]
// Self-checking bench for the protection control block
`default_nettype none
`include "npk_regs.svh"
module tb_nvm_page_key_protect_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   import npk_pkg::*;

   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, slv, key_wr, cmd_seq_start, cmd_launch, cmd_blocked;
   logic eeprom_page_select, key_write_enable, mass_erase_allowed, irq;
   logic [2:0] key_index;
   logic [1:0] eeprom_protect_code;
   logic [5:0] flash_protect_code;
   npk_byte_t nv_image = 8'hff, key_data, mem_wr_data, cmd_code, dbg_prot_data;
   npk_addr_t mem_wr_addr, cmd_addr;
   logic mem_wr_valid, cmd_valid, cmd_is_eeprom, dbg_prot_wr;
   int errors = 0, check_count = 0;
   npk_addr_t kaddr [3] = '{16'hffb0, 16'hffb7, 16'hffb8};
   npk_byte_t ccode [6] = '{8'h20, 8'h20, 8'h40, 8'h25, 8'h41, 8'h05};
   npk_addr_t caddr [6] = '{16'hfa00, 16'hf9ff, 16'h17f0, 16'h17ef, 16'h0000, 16'hfa00};
   logic cee [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   logic cblk [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

   always #4 pclk = ~pclk;

   npk_ctrl #(.ADDR_W(8)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .protection_nv_image(nv_image),
      .dbg_prot_wr(dbg_prot_wr), .dbg_prot_data(dbg_prot_data), .mem_wr_valid(mem_wr_valid),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .key_wr(key_wr),
      .key_index(key_index), .key_data(key_data), .cmd_seq_start(cmd_seq_start),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
      .cmd_is_eeprom(cmd_is_eeprom), .cmd_launch(cmd_launch), .cmd_blocked(cmd_blocked),
      .eeprom_page_select(eeprom_page_select), .key_write_enable(key_write_enable),
      .eeprom_protect_code(eeprom_protect_code), .flash_protect_code(flash_protect_code),
      .mass_erase_allowed(mass_erase_allowed), .irq(irq));

   npk_host_model u_host (.pclk(pclk), .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_is_eeprom(cmd_is_eeprom), .dbg_prot_wr(dbg_prot_wr),
      .dbg_prot_data(dbg_prot_data));

   task automatic conclude();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      if (n >= 20)
      begin
         errors++;
         $display("Error pready expected 1 seen timeout");
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask

   task automatic settle();
      @(posedge pclk);
      #1;
   endtask

   task automatic do_reset(input npk_byte_t img);
      presetn <= 1'b0;
      nv_image <= img;
      repeat (5) @(posedge pclk);
      #1;
      check("rst_out", {22'h0, eeprom_protect_code, flash_protect_code, mass_erase_allowed, irq},
         {22'h0, 2'h3, 6'h3f, 1'b1, 1'b0});
      @(posedge pclk);
      presetn <= 1'b1;
   endtask

   initial
   begin
      do_reset(8'hbe);
      rd_chk("prot_load", `NPK_OFS_PROT, 32'hbe);
      check("codes", {eeprom_protect_code, flash_protect_code}, 8'hbe);
      check("mass_ok", mass_erase_allowed, 1'b0);
      $display("test reset_load done");
      wr(`NPK_OFS_CONFIG, 32'hff);
      rd_chk("cfg", `NPK_OFS_CONFIG, 32'h60);
      check("page_key", {eeprom_page_select, key_write_enable}, 2'b11);
      foreach (kaddr[i])
      begin
         u_host.mem_write(kaddr[i], 8'h5a ^ 8'(i));
         check("route", {key_wr, cmd_seq_start}, i < 2 ? 2'b10 : 2'b01);
         if (i < 2)
            check("key", {key_index, key_data}, {kaddr[i][2:0], 8'h5a ^ 8'(i)});
      end
      wr(`NPK_OFS_CONFIG, 32'h00);
      check("page0", eeprom_page_select, 1'b0);
      u_host.mem_write(16'hffb3, 8'h11);
      check("seq_start", {key_wr, cmd_seq_start}, 2'b01);
      rd_chk("st_key", `NPK_OFS_STATUS, 32'h02);
      wr(`NPK_OFS_STATUS, 32'h02);
      $display("test key_route done");
      for (int i = 0; i < 6; i++)
      begin
         u_host.command(ccode[i], caddr[i], cee[i]);
         check("cmd", {cmd_launch, cmd_blocked}, {~cblk[i], cblk[i]});
      end
      settle();
      check("irq_masked", irq, 1'b0);
      rd_chk("st_viol", `NPK_OFS_STATUS, 32'h30);
      wr(`NPK_OFS_MASK, 32'h20);
      settle();
      check("irq", irq, 1'b1);
      wr(`NPK_OFS_STATUS, 32'h30);
      rd_chk("st_clr", `NPK_OFS_STATUS, 32'h00);
      settle();
      check("irq_clr", irq, 1'b0);
      $display("test commands done");
      wr(`NPK_OFS_PROT, 32'hff);
      rd_chk("prot_shrink", `NPK_OFS_PROT, 32'hbe);
      wr(`NPK_OFS_PROT, 32'h7f);
      rd_chk("prot_mixed", `NPK_OFS_PROT, 32'hbe);
      rd_chk("st_ref", `NPK_OFS_STATUS, 32'h01);
      wr(`NPK_OFS_PROT, 32'h7c);
      rd_chk("prot_widen", `NPK_OFS_PROT, 32'h7c);
      u_host.dbg_write(8'h3a);
      check("dbg_widen", {eeprom_protect_code, flash_protect_code}, 8'h3a);
      u_host.dbg_write(8'hff);
      check("dbg_shrink", {eeprom_protect_code, flash_protect_code}, 8'h3a);
      u_host.dbg_write(8'h18);
      u_host.command(`NPK_CMD_BYTE_PROG, 16'h0000, 1'b0);
      check("flash_all", {cmd_launch, cmd_blocked}, 2'b01);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", slv, 1'b1);
      $display("test protection done");
      do_reset(8'hff);
      settle();
      check("mass_ok", mass_erase_allowed, 1'b1);
      u_host.command(`NPK_CMD_MASS_ERASE, 16'h0000, 1'b0);
      check("mass_go", {cmd_launch, cmd_blocked}, 2'b10);
      $display("test mass_erase done");
      conclude();
   end
endmodule // tb_nvm_page_key_protect_ctrl
`default_nettype wire
